// *** led_defs.svh ***
// Register map, field positions, reset values and timing counts of the
// indicator and charger-detect block.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef LED_DEFS_SVH
`define LED_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ADDR_CTRL        8'h00
`define ADDR_LEVEL       8'h04
`define ADDR_PATTERN     8'h08
`define ADDR_DETECT      8'h0c
`define ADDR_STATUS      8'h10
`define ADDR_IRQ_STATUS  8'h14
`define ADDR_IRQ_MASK    8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_EN_ONE      0
`define CTRL_EN_TWO      1
`define CTRL_SLEEP_KEEP  2
`define CTRL_DETECT_MODE 3
`define LEVEL_ONE_LSB    0
`define LEVEL_TWO_LSB    8
`define PAT_ONE_LSB      0
`define PAT_TWO_LSB      8
`define PAT_DIV_LSB      16
`define DETECT_CFG_W     6
`define STAT_SENSE       0
`define STAT_FAULT_LSB   1
`define STAT_SLEEP       5
`define STAT_STEP_LSB    8
`define IRQ_SENSE        0

// ----------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------
`define CTRL_WMASK       32'h0000_000f
`define LEVEL_WMASK      32'h0000_0f0f
`define PATTERN_WMASK    32'h00ff_ffff
`define DETECT_WMASK     32'h0000_003f
`define IRQ_WMASK        32'h0000_0001
`define CTRL_RST         32'h0000_0000
`define LEVEL_RST        32'h0000_0404
`define PATTERN_RST      32'h0004_ffff
`define DETECT_RST       32'h0000_0000
`define IRQ_MASK_RST     32'h0000_0000

// ----------------------------------------------------------------------
// Bus responses and timing
// ----------------------------------------------------------------------
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`define CLK_PERIOD_NS    10
`define SLEW_STEP_NS     1000
`define SLEW_STEP_CYC    ((`SLEW_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** led_indicator_charger_detect.sv ***
// Indicator drivers and charger-detect front end with AXI4-Lite registers.
// Assumes fault, comparator, sleep and loose oscillator inputs are
// asynchronous pins and the bus master runs on CLK.
`timescale 1ns/1ps
`include "led_defs.svh"

module led_indicator_charger_detect
  import led_pkg::*;
#(
  parameter int LW = 4
) (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        SLEEP_PIN,
  input  wire logic        LOOSE_OSC,
  input  wire pin_fault_t  FAULT_ONE,
  input  wire pin_fault_t  FAULT_TWO,
  input  wire logic        DETECT_CMP,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [LW-1:0]    LEVEL_ONE,
  output logic [LW-1:0]    LEVEL_TWO,
  output logic             DRIVE_EN_ONE,
  output logic             DRIVE_EN_TWO,
  output detect_cfg_t      DETECT_DRIVE,
  output logic             IRQ
);

  logic [31:0] ctrl;
  logic [31:0] level_cfg;
  logic [31:0] pattern;
  logic [31:0] detect;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  logic [6:0]  sync_a;
  logic [6:0]  sync_b;
  logic        osc_prev;
  logic        osc_tick;
  logic [7:0]  div_cnt;
  logic [2:0]  step;
  logic        sleeping;
  logic        detect_mode;
  logic [1:0]  led_on;
  logic [3:0]  faults;
  logic        sense;
  logic        sense_prev;
  logic        sense_event;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_write;
  logic        next_aw_held;
  logic        next_w_held;
  logic        next_bvalid;
  logic        next_rvalid;
  logic [31:0] irq_clear;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = data[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `ADDR_CTRL || a == `ADDR_LEVEL || a == `ADDR_PATTERN ||
           a == `ADDR_DETECT || a == `ADDR_STATUS ||
           a == `ADDR_IRQ_STATUS || a == `ADDR_IRQ_MASK;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
    end else begin
      sync_a <= {DETECT_CMP, FAULT_TWO, FAULT_ONE, LOOSE_OSC, SLEEP_PIN};
      sync_b <= sync_a;
    end
  end
  assign sleeping    = sync_b[0];
  assign faults      = sync_b[5:2];
  assign detect_mode = ctrl[`CTRL_DETECT_MODE];

  // ----------------------------------------------------------------------
  // Shared blink sequencer
  // ----------------------------------------------------------------------
  // The loose oscillator is imprecise; blink rates drift with it.
  assign osc_tick = sync_b[1] && !osc_prev;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      osc_prev <= 1'b0;
      div_cnt  <= 8'h00;
      step     <= 3'h0;
    end else begin
      osc_prev <= sync_b[1];
      if (osc_tick) begin
        if (div_cnt >= pattern[`PAT_DIV_LSB +: 8]) begin
          div_cnt <= 8'h00;
          step    <= step + 3'h1;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end
  // One step index serves both pins, so their patterns stay in phase.
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      led_on[k] = ctrl[`CTRL_EN_ONE + k] &&
                  pattern[`PAT_ONE_LSB + 8*k + step] &&
                  !detect_mode &&
                  (!sleeping || ctrl[`CTRL_SLEEP_KEEP]);
    end
  end

  // ----------------------------------------------------------------------
  // Current sources
  // ----------------------------------------------------------------------
  led_slew #(.LW(LW), .STEP_CYC(`SLEW_STEP_CYC)) slew_one (
    .clk      (CLK),
    .srst     (SRST),
    .on       (led_on[0]),
    .target   (level_cfg[`LEVEL_ONE_LSB +: LW]),
    .level    (LEVEL_ONE),
    .drive_en (DRIVE_EN_ONE)
  );
  led_slew #(.LW(LW), .STEP_CYC(`SLEW_STEP_CYC)) slew_two (
    .clk      (CLK),
    .srst     (SRST),
    .on       (led_on[1]),
    .target   (level_cfg[`LEVEL_TWO_LSB +: LW]),
    .level    (LEVEL_TWO),
    .drive_en (DRIVE_EN_TWO)
  );

  // ----------------------------------------------------------------------
  // Detect routing
  // ----------------------------------------------------------------------
  // No sequencer here: software owns every phase of the detection.
  always_ff @(posedge CLK) begin
    if (SRST || !detect_mode) begin
      DETECT_DRIVE <= '0;
    end else begin
      DETECT_DRIVE <= detect_cfg_t'(detect[`DETECT_CFG_W-1:0]);
    end
  end

  // ----------------------------------------------------------------------
  // Sense bit and interrupt
  // ----------------------------------------------------------------------
  // Faults never switch the driver off; software decides.
  assign sense_event = sense ^ sense_prev;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sense      <= 1'b0;
      sense_prev <= 1'b0;
    end else begin
      sense      <= detect_mode ? (sync_b[6] && detect[5])
                                : (|faults);
      sense_prev <= sense;
    end
  end

  assign irq_clear = (do_write && aw_addr == `ADDR_IRQ_STATUS) ?
                     (merge(32'h0, w_data, w_strb) & `IRQ_WMASK) : 32'h0;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      irq_status <= 32'h0;
      IRQ        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) |
                    {31'h0, sense_event};
      IRQ        <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  assign aw_take      = AWVALID && AWREADY;
  assign w_take       = WVALID && WREADY;
  assign ar_take      = ARVALID && ARREADY;
  assign do_write     = aw_held && w_held && !BVALID;
  assign next_aw_held = !do_write && (aw_held || aw_take);
  assign next_w_held  = !do_write && (w_held || w_take);
  assign next_bvalid  = do_write || (BVALID && !BREADY);
  assign next_rvalid  = ar_take || (RVALID && !RREADY);

  always_ff @(posedge CLK) begin
    if (SRST) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= `RESP_OKAY;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      AWREADY <= !next_aw_held && !next_bvalid;
      WREADY  <= !next_w_held && !next_bvalid;
      BVALID  <= next_bvalid;
      if (aw_take) begin
        aw_addr <= AWADDR;
      end
      if (w_take) begin
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        BRESP <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // The host enables a pin by writing its level, pattern and enable.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctrl      <= `CTRL_RST;
      level_cfg <= `LEVEL_RST;
      pattern   <= `PATTERN_RST;
      detect    <= `DETECT_RST;
      irq_mask  <= `IRQ_MASK_RST;
    end else if (do_write) begin
      unique case (aw_addr)
        `ADDR_CTRL: begin
          ctrl <= merge(ctrl, w_data, w_strb) & `CTRL_WMASK;
        end
        `ADDR_LEVEL: begin
          level_cfg <= merge(level_cfg, w_data, w_strb) & `LEVEL_WMASK;
        end
        `ADDR_PATTERN: begin
          pattern <= merge(pattern, w_data, w_strb) & `PATTERN_WMASK;
        end
        `ADDR_DETECT: begin
          detect <= merge(detect, w_data, w_strb) & `DETECT_WMASK;
        end
        `ADDR_IRQ_MASK: begin
          irq_mask <= merge(irq_mask, w_data, w_strb) & `IRQ_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0;
      RRESP   <= `RESP_OKAY;
    end else begin
      ARREADY <= !next_rvalid;
      RVALID  <= next_rvalid;
      if (ar_take) begin
        RRESP <= mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
        unique case (ARADDR)
          `ADDR_CTRL:       RDATA <= ctrl;
          `ADDR_LEVEL:      RDATA <= level_cfg;
          `ADDR_PATTERN:    RDATA <= pattern;
          `ADDR_DETECT:     RDATA <= detect;
          `ADDR_STATUS:     RDATA <= {21'h0, step, 2'h0, sleeping,
                                      faults, sense};
          `ADDR_IRQ_STATUS: RDATA <= irq_status;
          `ADDR_IRQ_MASK:   RDATA <= irq_mask;
          default:          RDATA <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence fault_onset_s;
    $rose(faults[0]) && DRIVE_EN_ONE && LEVEL_ONE > 1;
  endsequence

  fault_keep_a: assert property (fault_onset_s |=> DRIVE_EN_ONE)
    else $error("fault switched the driver off");
  blink_sync_a: assert property (led_on[0] && led_on[1] |->
    pattern[`PAT_ONE_LSB + step] && pattern[`PAT_TWO_LSB + step])
    else $error("pins use different pattern steps");
  osc_step_a: assert property (!$stable(step) |-> $past(osc_tick))
    else $error("blink step moved without oscillator edge");
  sleep_off_a: assert property (sleeping && !ctrl[`CTRL_SLEEP_KEEP] |->
    led_on == 2'b00)
    else $error("driver on in sleep without keep");
  detect_route_a: assert property (##1 detect_mode |=>
    DETECT_DRIVE == detect_cfg_t'($past(detect[`DETECT_CFG_W-1:0])))
    else $error("detect routing does not follow register");
  led_mode_a: assert property (!detect_mode |=> DETECT_DRIVE == '0)
    else $error("detect drive active in indicator mode");
  sense_irq_a: assert property (sense_event |=>
    irq_status[`IRQ_SENSE])
    else $error("sense change raised no interrupt");
  irq_hold_a: assert property (irq_status[`IRQ_SENSE] &&
    !irq_clear[`IRQ_SENSE] |=> irq_status[`IRQ_SENSE])
    else $error("interrupt dropped without clear");
endmodule

// *** led_load_model.sv ***
// Behavioural load on the two indicator pins: LEDs or a USB port.
// Assumes the bench commands LED faults and the attached port kind.
`timescale 1ns/1ps

module led_load_model
  import led_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        drive_en_one,
  input  wire logic        drive_en_two,
  input  wire detect_cfg_t detect_drive,
  input  wire logic [1:0]  open_cmd,
  input  wire logic [1:0]  short_cmd,
  input  wire logic [1:0]  port_kind,
  output pin_fault_t       fault_one,
  output pin_fault_t       fault_two,
  output logic             detect_cmp
);
  // ------------------------------------------------------------------
  // Pin behaviour
  // ------------------------------------------------------------------
  logic d_plus;
  logic d_minus;
  logic idle_bit = 1'b0;

  // A fault is only sensed while the source really drives the pin.
  assign fault_one = {short_cmd[0], open_cmd[0]} & {2{drive_en_one}};
  assign fault_two = {short_cmd[1], open_cmd[1]} & {2{drive_en_two}};

  // Kind 0 standard, 1 charging port, 2 dedicated charger (lines shorted).
  assign d_plus  = detect_drive.src_one
                 | (port_kind == 2'h2 & detect_drive.src_two);
  assign d_minus = detect_drive.src_two
                 | (port_kind != 2'h0 & detect_drive.src_one);

  // An unused comparator wanders, so the block must not rely on it.
  always @(posedge clk) idle_bit <= ~idle_bit;
  assign detect_cmp = !detect_drive.cmp_en ? idle_bit :
                      detect_drive.cmp_pin_two ? d_minus : d_plus;
endmodule

// *** led_pkg.sv ***
// Types shared by the indicator and charger-detect block.
// Assumes led_defs.svh supplies the field widths.
`include "led_defs.svh"

package led_pkg;

  // Routing of the single detect source, sink and comparator.
  typedef struct packed {
    logic cmp_en;
    logic cmp_pin_two;
    logic sink_two;
    logic sink_one;
    logic src_two;
    logic src_one;
  } detect_cfg_t;

  // Fault comparator outputs of one indicator pin.
  typedef struct packed {
    logic shorted;
    logic open;
  } pin_fault_t;

endpackage

// *** led_slew.sv ***
// Current ramp for one indicator source.
// Assumes target and on come from logic on the same clock.
`timescale 1ns/1ps
`include "led_defs.svh"

module led_slew
  import led_pkg::*;
#(
  parameter int LW       = 4,
  parameter int STEP_CYC = `SLEW_STEP_CYC
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          on,
  input  wire logic [LW-1:0] target,
  output logic      [LW-1:0] level,
  output logic               drive_en
);

  logic [15:0]   step_cnt;
  logic          step_tick;
  logic [LW-1:0] want;
  logic [LW-1:0] next_level;

  // ----------------------------------------------------------------------
  // Slew step timer
  // ----------------------------------------------------------------------
  assign step_tick = (step_cnt == 16'(STEP_CYC - 1));

  always_ff @(posedge clk) begin
    if (srst || step_tick) begin
      step_cnt <= 16'h0000;
    end else begin
      step_cnt <= step_cnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Ramp
  // ----------------------------------------------------------------------
  // A hard step would kick the crystal oscillator next to the pin.
  always_comb begin
    want       = on ? target : '0;
    next_level = level;
    if (step_tick && level < want) begin
      next_level = level + 1'b1;
    end else if (step_tick && level > want) begin
      next_level = level - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      level    <= '0;
      drive_en <= 1'b0;
    end else begin
      level    <= next_level;
      drive_en <= (next_level != '0) || on;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence level_step_s;
    $changed(level);
  endsequence

  reset_hiz_a: assert property ($fell(srst) |->
    !drive_en && level == '0)
    else $error("driver active right after reset");
  // A lowered target ramps down through higher codes, so only rises count.
  level_cap_a: assert property ((level_step_s and
    ($past(on) && level > $past(level))) |-> level <= $past(target))
    else $error("level exceeds programmed current");
  slew_rate_a: assert property (level_step_s |=>
    $stable(level)[*8])
    else $error("current stepped too fast");

endmodule

// *** test_led_indicator_charger_detect.sv ***
// Self-checking bench for the indicator and charger-detect block.
// Assumes led_defs.svh, led_pkg and led_load_model are compiled first.
`timescale 1ns/1ps
`include "led_defs.svh"

module test_led_indicator_charger_detect
  import led_pkg::*;
;
  // ------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------
  logic        clk = 1'b0;
  logic        srst, sleep_pin, loose_osc, detect_cmp, irq;
  logic [7:0]  awaddr, araddr, pat;
  logic [31:0] wdata, rdata, rd, rnd;
  logic [3:0]  wstrb, level_one, level_two, lv;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        drive_en_one, drive_en_two;
  logic [1:0]  bresp, rresp, resp, open_cmd, short_cmd, port_kind;
  detect_cfg_t detect_drive;
  pin_fault_t  fault_one, fault_two;
  int          n_errors = 0, cmp_count = 0, seed = 60, ticks;

  led_indicator_charger_detect i_led_indicator_charger_detect (
    .CLK(clk), .SRST(srst), .SLEEP_PIN(sleep_pin), .LOOSE_OSC(loose_osc),
    .FAULT_ONE(fault_one), .FAULT_TWO(fault_two), .DETECT_CMP(detect_cmp),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
    .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .LEVEL_ONE(level_one), .LEVEL_TWO(level_two),
    .DRIVE_EN_ONE(drive_en_one), .DRIVE_EN_TWO(drive_en_two),
    .DETECT_DRIVE(detect_drive), .IRQ(irq));

  led_load_model i_led_load_model (
    .clk(clk), .drive_en_one(drive_en_one), .drive_en_two(drive_en_two),
    .detect_drive(detect_drive), .open_cmd(open_cmd),
    .short_cmd(short_cmd), .port_kind(port_kind), .fault_one(fault_one),
    .fault_two(fault_two), .detect_cmp(detect_cmp));

  // ------------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Address and data go out together; each is dropped once it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) aw_done = 1'b1;
      if (wready) w_done = 1'b1;
      awvalid <= !aw_done;
      wvalid <= !w_done;
    end while (!(aw_done && w_done));
    do @(posedge clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic put(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, resp);
  endtask

  task automatic rchk(input string w, input logic [7:0] a,
                      input logic [31:0] m, e);
    rdr(a, rd, resp);
    chk(w, rd & m, e);
  endtask

  task automatic osc_tick;
    repeat (4) @(posedge clk);
    loose_osc <= 1'b1;
    repeat (4) @(posedge clk);
    loose_osc <= 1'b0;
  endtask

  // Charger ports answer on D- first; only a dedicated one mirrors D+.
  function automatic logic exp_sense(input logic [1:0] k, input logic sec);
    return sec ? (k == 2'h2) : (k != 2'h0);
  endfunction

  function automatic logic [3:0] exp_level(input logic [7:0] p,
                                           input int step);
    return p[step % 8] ? 4'h1 : 4'h0;
  endfunction

  // ------------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------------
  initial forever #5 clk = ~clk;

  initial begin
    #900000;
    n_errors++;
    tally_and_finish;
  end

  initial begin
    srst = 1'b1;
    {sleep_pin, loose_osc, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, open_cmd, short_cmd, port_kind} = '0;
    wstrb = 4'hf;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    cyc(2);
    chk("pins idle", {drive_en_one, drive_en_two, level_one, level_two,
                      detect_drive, irq}, 32'h0);
    rchk("ctrl rst", `ADDR_CTRL, 32'hffff_ffff, `CTRL_RST);
    rchk("level rst", `ADDR_LEVEL, 32'hffff_ffff, `LEVEL_RST);
    rchk("pat rst", `ADDR_PATTERN, 32'hffff_ffff, `PATTERN_RST);
    rchk("det rst", `ADDR_DETECT, 32'hffff_ffff, `DETECT_RST);
    rchk("mask rst", `ADDR_IRQ_MASK, 32'hffff_ffff, `IRQ_MASK_RST);
    rdr(8'h1c, rd, resp);
    chk("bad rd resp", resp, `RESP_SLVERR);
    chk("bad rd data", rd, 32'h0);
    wr(8'h1c, 32'h1, resp);
    chk("bad wr", resp, `RESP_SLVERR);

    rnd = $random(seed);
    lv = {1'b1, rnd[2:0]};
    put(`ADDR_LEVEL, {20'h0, 4'h2, 4'h0, lv});
    put(`ADDR_CTRL, 32'h3);
    cyc(150);
    chk("ramp slow", {drive_en_one, level_one < lv}, 2'h3);
    cyc(lv * 100 + 100);
    chk("level one", level_one, lv);
    chk("level two", level_two, 4'h2);

    rnd = $random(seed);
    pat = rnd[7:0];
    rnd = $random(seed);
    ticks = 1 + rnd[2:0];
    put(`ADDR_LEVEL, 32'h0101);
    put(`ADDR_PATTERN, {16'h0, ~pat, pat});
    cyc(1700);
    repeat (ticks) osc_tick;
    cyc(250);
    chk("blink one", level_one, exp_level(pat, ticks));
    chk("blink two", level_two, exp_level(~pat, ticks));
    rchk("step", `ADDR_STATUS, 32'h700, (ticks % 8) << 8);

    put(`ADDR_PATTERN, 32'hffff);
    put(`ADDR_LEVEL, {20'h0, 4'h3, 4'h0, lv});
    cyc(1700);
    sleep_pin <= 1'b1;
    cyc(1700);
    chk("sleep off", {drive_en_one, level_one}, 5'h0);
    rchk("sleeping", `ADDR_STATUS, 32'h20, 32'h20);
    put(`ADDR_CTRL, 32'h7);
    cyc(1700);
    chk("sleep keep", level_one, lv);
    sleep_pin <= 1'b0;

    put(`ADDR_IRQ_MASK, 32'h1);
    open_cmd <= 2'h1;
    cyc(8);
    rchk("open one", `ADDR_STATUS, 32'h3, 32'h3);
    chk("irq drive", {irq, drive_en_one}, 2'h3);
    put(`ADDR_IRQ_STATUS, 32'h1);
    rchk("cleared", `ADDR_IRQ_STATUS, 32'h1, 32'h0);
    short_cmd <= 2'h2;
    cyc(8);
    rchk("same sense", `ADDR_IRQ_STATUS, 32'h1, 32'h0);
    rchk("short two", `ADDR_STATUS, 32'h1f, 32'h13);
    {open_cmd, short_cmd} <= 4'h0;
    cyc(8);
    rchk("new change", `ADDR_IRQ_STATUS, 32'h1, 32'h1);
    put(`ADDR_IRQ_MASK, 32'h0);
    cyc(2);
    chk("masked", irq, 1'b0);
    put(`ADDR_IRQ_STATUS, 32'h1);

    put(`ADDR_CTRL, 32'hb);
    cyc(1700);
    chk("leds off", {drive_en_one, drive_en_two}, 2'h0);
    for (int k = 0; k < 3; k++) begin
      port_kind <= 2'(k);
      put(`ADDR_DETECT, 32'h39);
      cyc(6);
      chk("primary cfg", detect_drive, 6'h39);
      rchk("primary", `ADDR_STATUS, 32'h1, exp_sense(2'(k), 1'b0));
      put(`ADDR_DETECT, 32'h26);
      cyc(6);
      chk("second cfg", detect_drive, 6'h26);
      rchk("second", `ADDR_STATUS, 32'h1, exp_sense(2'(k), 1'b1));
    end
    rchk("detect irq", `ADDR_IRQ_STATUS, 32'h1, 32'h1);
    put(`ADDR_CTRL, 32'h0);
    cyc(4);
    chk("detect free", detect_drive, 6'h0);
    tally_and_finish;
  end
endmodule
